// File: rtl/sfrdec_top.sv
// Direct-space decoder, bit access engine and xram page register.
// Assumes the core holds each request stable for one cycle and reads data one cycle later.
`timescale 1ns/10ps
module sfrdec_top
(
   input wire logic CLK,
   input wire logic RST,
   input wire logic ACC_VALID,
   input wire sfrdec_pkg::sfrdec_op_t ACC_OP,
   input wire logic ACC_WRITE,
   input wire logic [7:0] ACC_ADDR,
   input wire logic [7:0] ACC_WDATA,
   input wire logic XMOV_VALID,
   input wire logic XMOV_WIDE,
   input wire logic [7:0] XMOV_LOW,
   input wire logic [15:0] XMOV_PTR,
   input wire logic [7:0] PERIPH_RDATA,
   output logic SFR_SEL,
   output logic UPPER_RAM_SEL,
   output logic LOWER_RAM_SEL,
   output logic PERIPH_SEL,
   output logic BIT_REFUSED,
   output logic [7:0] RDATA,
   output logic [15:0] XMOV_ADDR,
   output logic [8:0] XRAM_INDEX,
   output logic PAGE_SELECT
);
   import sfrdec_pkg::*;

   // ==========================================================
   // Decode helpers
   function automatic logic in_sfr_space(input logic [7:0] a);
      in_sfr_space = (a >= SFR_BASE) && (a <= SFR_TOP);
   endfunction

   function automatic logic bit_capable(input logic [7:0] a);
      bit_capable = (a[2:0] == BITADR_LOW_ZERO);
   endfunction

   typedef struct packed
   {
      logic page_sel_r;
      logic [7:0] rdata_r;
      logic [15:0] xaddr_r;
      logic refused_r;
   } sfrdec_state_t;

   sfrdec_state_t st_r;
   sfrdec_state_t st_nxt;
   logic [7:0] reg_addr;
   logic [2:0] bit_pos;
   logic is_sfr;
   logic page_hit;
   logic [7:0] page_byte;
   logic [7:0] cur_byte;

   // ==========================================================
   // Address decode
   // Bit operand: high five bits pick the register, low three the bit
   assign reg_addr = (ACC_OP == SFRDEC_OP_BIT) ? {ACC_ADDR[7:3], BITADR_LOW_ZERO} : ACC_ADDR;
   assign bit_pos = ACC_ADDR[2:0];
   assign is_sfr = ACC_VALID && (ACC_OP != SFRDEC_OP_IND) && in_sfr_space(reg_addr);
   assign page_hit = is_sfr && (reg_addr == XRAM_PAGE_ADDR);
   assign page_byte = {7'h00, st_r.page_sel_r} & XRAM_PAGE_READ_MASK;
   assign cur_byte = page_hit ? page_byte : PERIPH_RDATA;

   // Steering outputs are combinational so the core sees them in the request cycle
   always_comb
   begin
      SFR_SEL = is_sfr;
      UPPER_RAM_SEL = ACC_VALID && (ACC_OP == SFRDEC_OP_IND) && ACC_ADDR[7];
      LOWER_RAM_SEL = ACC_VALID && !is_sfr && !UPPER_RAM_SEL;
      PERIPH_SEL = is_sfr && !page_hit;
      // Unoccupied addresses still reach peripherals; their answer is not defined
      // A bit operand always resolves to a 0/8 register, so this flags only a decode fault
      BIT_REFUSED = is_sfr && ACC_OP == SFRDEC_OP_BIT && !bit_capable(reg_addr);
   end

   // ==========================================================
   // Next state
   always_comb
   begin
      st_nxt = st_r;
      st_nxt.refused_r = BIT_REFUSED;
      if (page_hit && ACC_WRITE && !BIT_REFUSED)
      begin
         if (ACC_OP == SFRDEC_OP_BIT)
         begin
            // Only bit 0 exists; other bit positions hit unused zero bits
            if (bit_pos == 3'(PAGE_BIT_POS))
               st_nxt.page_sel_r = ACC_WDATA[0];
         end
         else
            st_nxt.page_sel_r = ACC_WDATA[PAGE_BIT_POS];
      end
      if (is_sfr && !ACC_WRITE)
         st_nxt.rdata_r = (ACC_OP == SFRDEC_OP_BIT) ? {7'h00, cur_byte[bit_pos]} : cur_byte;
      if (XMOV_VALID)
      begin
         if (XMOV_WIDE)
            st_nxt.xaddr_r = XMOV_PTR;
         else
            st_nxt.xaddr_r = {page_byte, XMOV_LOW};
      end
   end

   // ==========================================================
   // State register
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         st_r.page_sel_r <= XRAM_PAGE_RESET[0];
         st_r.rdata_r <= 8'h00;
         st_r.xaddr_r <= 16'h0000;
         st_r.refused_r <= 1'b0;
      end
      else
         st_r <= st_nxt;
   end

   assign RDATA = st_r.rdata_r;
   assign XMOV_ADDR = st_r.xaddr_r;
   // Top seven bits dropped so 512 bytes repeat over 64k
   assign XRAM_INDEX = st_r.xaddr_r[8:0] & XRAM_ADDR_MASK;
   assign PAGE_SELECT = st_r.page_sel_r;

   // ==========================================================
   // Checks
   property p_page_write;
      @(posedge CLK) disable iff (RST)
      (page_hit && ACC_WRITE && ACC_OP == SFRDEC_OP_BYTE) |=> (PAGE_SELECT == $past(ACC_WDATA[0]));
   endproperty
   a_page_write: assert property (p_page_write) else $error("page write lost");

   property p_page_read;
      @(posedge CLK) disable iff (RST)
      (page_hit && !ACC_WRITE && ACC_OP == SFRDEC_OP_BYTE) |=> (RDATA[7:1] == 7'h00);
   endproperty
   a_page_read: assert property (p_page_read) else $error("page upper bits nonzero");

   sequence s_short_move;
      XMOV_VALID && !XMOV_WIDE;
   endsequence
   property p_short_move;
      @(posedge CLK) disable iff (RST)
      s_short_move |=> (XMOV_ADDR == {7'h00, $past(PAGE_SELECT), $past(XMOV_LOW)});
   endproperty
   a_short_move: assert property (p_short_move) else $error("short move page wrong");

   property p_page_addr;
      @(posedge CLK) disable iff (RST)
      page_hit |-> (ACC_ADDR == XRAM_PAGE_ADDR && ACC_OP == SFRDEC_OP_BYTE);
   endproperty
   a_page_addr: assert property (p_page_addr) else $error("page decode wrong");

   property p_sfr_range;
      @(posedge CLK) disable iff (RST)
      (ACC_VALID && ACC_OP == SFRDEC_OP_BYTE) |-> (SFR_SEL == ACC_ADDR[7]);
   endproperty
   a_sfr_range: assert property (p_sfr_range) else $error("direct steering wrong");

   property p_bit_refuse;
      @(posedge CLK) disable iff (RST)
      (SFR_SEL && ACC_OP == SFRDEC_OP_BIT) |-> (PERIPH_SEL && !BIT_REFUSED);
   endproperty
   a_bit_refuse: assert property (p_bit_refuse) else $error("bit access gate wrong");

   property p_periph_sel;
      @(posedge CLK) disable iff (RST)
      (ACC_VALID && ACC_OP == SFRDEC_OP_BYTE && ACC_ADDR[7])
         |-> (PERIPH_SEL == (ACC_ADDR != XRAM_PAGE_ADDR));
   endproperty
   a_periph_sel: assert property (p_periph_sel) else $error("peripheral select wrong");

   property p_bit_read;
      @(posedge CLK) disable iff (RST)
      (PERIPH_SEL && ACC_OP == SFRDEC_OP_BIT && !ACC_WRITE)
         |=> (RDATA == {7'h00, $past(PERIPH_RDATA[ACC_ADDR[2:0]])});
   endproperty
   a_bit_read: assert property (p_bit_read) else $error("bit read picked wrong bit");

   property p_page_hold;
      @(posedge CLK) disable iff (RST)
      !(page_hit && ACC_WRITE) |=> $stable(PAGE_SELECT);
   endproperty
   a_page_hold: assert property (p_page_hold) else $error("page changed without write");

   property p_xmov_hold;
      @(posedge CLK) disable iff (RST)
      !XMOV_VALID |=> $stable(XMOV_ADDR);
   endproperty
   a_xmov_hold: assert property (p_xmov_hold) else $error("move address changed idle");

   property p_lower_ram;
      @(posedge CLK) disable iff (RST)
      (ACC_VALID && ACC_OP == SFRDEC_OP_IND && !ACC_ADDR[7])
         |-> (LOWER_RAM_SEL && !UPPER_RAM_SEL && !SFR_SEL);
   endproperty
   a_lower_ram: assert property (p_lower_ram) else $error("low indirect misrouted");

   property p_wide_move;
      @(posedge CLK) disable iff (RST)
      (XMOV_VALID && XMOV_WIDE) |=> (XRAM_INDEX == $past(XMOV_PTR[8:0]));
   endproperty
   a_wide_move: assert property (p_wide_move) else $error("wide move index wrong");

   property p_indirect;
      @(posedge CLK) disable iff (RST)
      (ACC_VALID && ACC_OP == SFRDEC_OP_IND && ACC_ADDR[7]) |-> (UPPER_RAM_SEL && !SFR_SEL);
   endproperty
   a_indirect: assert property (p_indirect) else $error("indirect went to registers");

   property p_bit_write;
      @(posedge CLK) disable iff (RST)
      (ACC_VALID && ACC_WRITE && ACC_OP == SFRDEC_OP_BIT) |=> $stable(PAGE_SELECT);
   endproperty
   a_bit_write: assert property (p_bit_write) else $error("bit write touched page");
endmodule

// File: shared/sfrdec_pkg.sv
// Constants for the special function register decoder and xram page register.
// Assumes an 8051-style core presenting direct, indirect, bit and external accesses.
package sfrdec_pkg;
   // ==========================================================
   // Address map
   localparam logic [7:0] SFR_BASE = 8'h80;
   localparam logic [7:0] SFR_TOP = 8'hff;
   localparam logic [7:0] XRAM_PAGE_ADDR = 8'haa;
   localparam logic [7:0] XRAM_PAGE_RESET = 8'h00;
   localparam logic [7:0] XRAM_PAGE_READ_MASK = 8'h01;
   localparam int PAGE_BIT_POS = 0;
   localparam logic [2:0] BITADR_LOW_ZERO = 3'h0;
   localparam logic [8:0] XRAM_ADDR_MASK = 9'h1ff;
   // Operation codes presented by the core
   typedef enum logic [1:0]
   {
      SFRDEC_OP_BYTE = 2'h0,
      SFRDEC_OP_BIT = 2'h1,
      SFRDEC_OP_IND = 2'h2
   } sfrdec_op_t;
endpackage

// File: test/sfrdec_core_model.sv
// Core-side request driver for the register-space decoder.
// Assumes the decoder samples requests on the rising edge.
`timescale 1ns/10ps
module sfrdec_core_model
(
   input wire logic clk,
   output logic acc_valid,
   output sfrdec_pkg::sfrdec_op_t acc_op,
   output logic acc_write,
   output logic [7:0] acc_addr,
   output logic [7:0] acc_wdata,
   output logic xmov_valid,
   output logic xmov_wide,
   output logic [7:0] xmov_low,
   output logic [15:0] xmov_ptr
);
   import sfrdec_pkg::*;
   // ==========================================
   // Requests change on the falling edge
   initial
   begin
      {acc_valid, acc_write, xmov_valid, xmov_wide} = 4'h0;
      acc_op = SFRDEC_OP_BYTE;
      {acc_addr, acc_wdata, xmov_low, xmov_ptr} = 40'h0;
   end
   // Callers keep to occupied addresses
   task automatic acc(input sfrdec_op_t op, input logic w, input logic [7:0] a, d);
      @(negedge clk);
      xmov_valid = 1'b0;
      xmov_ptr = ~xmov_ptr;
      acc_valid = 1'b1;
      acc_op = op;
      acc_write = w;
      acc_addr = a;
      acc_wdata = d;
   endtask
   task automatic xmov(input logic wide, input logic [7:0] lo, input logic [15:0] p);
      @(negedge clk);
      acc_valid = 1'b0;
      acc_addr = ~acc_addr;
      xmov_valid = 1'b1;
      xmov_wide = wide;
      xmov_low = lo;
      xmov_ptr = p;
   endtask
   // Released lines invert, so stale values never pass for live ones
   task automatic idle();
      @(negedge clk);
      acc_valid = 1'b0;
      xmov_valid = 1'b0;
      acc_addr = ~acc_addr;
      xmov_ptr = ~xmov_ptr;
   endtask
endmodule

// File: test/test_sfr_space_decode_xram_page.sv
// Self-checking bench for the register-space decoder and page register.
// Assumes the core model drives requests; peripheral data comes from here.
`timescale 1ns/10ps
module test_sfr_space_decode_xram_page;
   import sfrdec_pkg::*;
   logic CLK = 1'b0;
   logic RST = 1'b1;
   logic [7:0] PERIPH_RDATA = 8'h0;
   logic av, aw, xv, xw, sfr, up, lo, bref, pg, ps;
   int exp_rd[$];
   sfrdec_op_t op;
   logic [7:0] aa, ad, xl, rd, v, pd, l;
   logic [15:0] xp, xa, p;
   logic [8:0] xi;
   logic [31:0] seed = 32'hf2cd;
   int page, failures, checks;
   sfrdec_top i_sfrdec_top (.CLK(CLK), .RST(RST), .ACC_VALID(av), .ACC_OP(op), .ACC_WRITE(aw),
      .ACC_ADDR(aa), .ACC_WDATA(ad), .XMOV_VALID(xv), .XMOV_WIDE(xw), .XMOV_LOW(xl),
      .XMOV_PTR(xp), .PERIPH_RDATA(PERIPH_RDATA), .SFR_SEL(sfr), .UPPER_RAM_SEL(up),
      .LOWER_RAM_SEL(lo), .PERIPH_SEL(ps), .BIT_REFUSED(bref), .RDATA(rd), .XMOV_ADDR(xa),
      .XRAM_INDEX(xi), .PAGE_SELECT(pg));
   sfrdec_core_model i_sfrdec_core_model (.clk(CLK), .acc_valid(av), .acc_op(op),
      .acc_write(aw), .acc_addr(aa), .acc_wdata(ad), .xmov_valid(xv), .xmov_wide(xw),
      .xmov_low(xl), .xmov_ptr(xp));
   // ==========================================
   // Clock, then a watchdog far beyond the ~100 cycles needed
   initial forever #2 CLK = ~CLK;
   initial
   begin
      #8000;
      failures++;
      tally_and_finish();
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks=%0d failures=%0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // Reset, then random page writes, moves and steering, back to back
   initial
   begin
      repeat (20) @(posedge CLK);
      @(negedge CLK);
      RST = 1'b0;
      #1 chk(16'(pg), 16'h0);
      chk(xa, 16'h0);
      chk(16'(rd), 16'h0);
      $display("reset test done");
      for (int i = 0; i < 8; i++)
      begin
         v = 8'(rnd());
         l = 8'(rnd());
         p = 16'(rnd());
         pd = 8'(rnd());
         PERIPH_RDATA = pd;
         page = int'(v[0]);
         i_sfrdec_core_model.acc(SFRDEC_OP_BYTE, 1'b1, XRAM_PAGE_ADDR, v);
         i_sfrdec_core_model.xmov(1'b0, l, p);
         #1 chk(16'(pg), 16'(page));
         i_sfrdec_core_model.acc(SFRDEC_OP_BYTE, 1'b0, XRAM_PAGE_ADDR, 8'h0);
         exp_rd.push_back(page);
         #1 chk(16'(sfr), 16'h1);
         chk(16'(ps), 16'h0);
         chk(xa, {7'h0, 1'(page), l});
         chk(16'(xi), {7'h0, 1'(page), l});
         i_sfrdec_core_model.xmov(1'b1, l, p);
         #1 chk(16'(rd), 16'(exp_rd.pop_front()));
         i_sfrdec_core_model.acc(SFRDEC_OP_BYTE, 1'b0, 8'h81, 8'h0);
         exp_rd.push_back(int'(pd));
         #1 chk(16'(xi), 16'(p[8:0]));
         chk(16'(ps), 16'h1);
         i_sfrdec_core_model.acc(SFRDEC_OP_IND, 1'b0, 8'h80 | l, 8'h0);
         #1 chk(16'(up), 16'h1);
         chk(16'(rd), 16'(exp_rd.pop_front()));
         // Bit 4 cleared so the bit lands on an occupied 0/8 register
         i_sfrdec_core_model.acc(SFRDEC_OP_BIT, 1'b0, 8'h80 | (v & 8'h6f), 8'h0);
         exp_rd.push_back(int'(pd[v[2:0]]));
         #1 chk(16'(bref), 16'h0);
         i_sfrdec_core_model.acc(SFRDEC_OP_BYTE, 1'b0, 8'h7f & l, 8'h0);
         #1 chk(16'({sfr, lo}), 16'h1);
         chk(16'(rd), 16'(exp_rd.pop_front()));
         // Bit address 0xaa belongs to the 0xa8 register, never to the page register
         i_sfrdec_core_model.acc(SFRDEC_OP_BIT, 1'b1, XRAM_PAGE_ADDR, ~v);
         #1 chk(16'({sfr, ps, bref}), 16'h6);
         i_sfrdec_core_model.idle();
         #1 chk(16'(pg), 16'(page));
      end
      $display("page test done");
      // Reset in mid-run must clear a set page bit
      i_sfrdec_core_model.acc(SFRDEC_OP_BYTE, 1'b1, XRAM_PAGE_ADDR, 8'hff);
      i_sfrdec_core_model.idle();
      #1 chk(16'(pg), 16'h1);
      @(negedge CLK);
      RST = 1'b1;
      repeat (2) @(negedge CLK);
      RST = 1'b0;
      #1 chk(16'({pg, rd}), 16'h0);
      chk(xa, 16'h0);
      $display("mid-run reset test done");
      tally_and_finish();
   end
endmodule
